// file: rtl/flash_prog_pkg.sv
// Package for the flash page programming sequencer: address map, result bit layout,
// page geometry, carried structs and state enumeration.
// Assumes a 32-bit CPU address space with flash, download RAM and source memories.
package flash_prog_pkg;
    // Page geometry
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_IDX_W = 7;
    // Flash window in the CPU address space
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_LIMIT = 32'h0007_FFFF;
    // Area holding the downloaded routine, in on-chip RAM
    localparam logic [31:0] DL_BASE = 32'h00FF_B000;
    localparam logic [31:0] DL_LIMIT = 32'h00FF_BFFF;
    // Supported frequency setting, in units of 10 kHz
    localparam logic [15:0] FREQ_MIN = 16'h0320;
    localparam logic [15:0] FREQ_MAX = 16'h09C4;
    // Result bit positions
    localparam int BIT_SUCCESS = 0;
    localparam int BIT_FREQ = 1;
    localparam int BIT_BRANCH = 2;
    localparam int BIT_DEST = 1;
    localparam int BIT_SRC = 2;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [6:0] ALIGN_ZERO = 7'h00;
    // Byte written from the source memory into the flash
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] data;
    } flash_write_t;
    // Parameter set handed in by software
    typedef struct packed {
        logic [31:0] reg_a;
        logic [31:0] reg_b;
    } call_params_t;
    typedef enum logic [2:0] {IDLE, CHECK, FETCH, WAIT_RD, WRITE, DONE} seq_state_t;
endpackage : flash_prog_pkg

// file: rtl/page_buffer.sv
// Page staging buffer: 128 bytes, one write port and one registered read port.
// Assumes writer and reader share clk_in.
`timescale 1ns/1ps
`default_nettype none
module page_buffer
    import flash_prog_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [PAGE_IDX_W-1:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    // Read port
    input wire logic [PAGE_IDX_W-1:0] rd_idx_in,
    output logic [7:0] rd_data_out
);
    // Storage array, no reset so it maps to RAM
    logic [7:0] mem [PAGE_BYTES];

    // Write and registered read
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_idx_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_idx_in];
    end
endmodule : page_buffer
`default_nettype wire

// file: rtl/flash_program_param_check.sv
// Flash page programming sequencer with parameter checks and pass/fail result.
// Assumes a source memory answering a read one cycle after its strobe, and a flash
// write port that takes one byte per strobe.
// Programming parameters arrive as one struct and are latched once per call,
// so the caller need hold nothing after the request edge.
// Operation
// - Initialization result bits seven to three zero
// - Bit two flags bad branch address
// - Bit one flags unsupported frequency
// - Bit zero flags initialization failure
// - Destination outside flash is an error
// - Unaligned destination sets destination error bit
// - Valid request writes 128 consecutive bytes
// - Source inside flash sets source error bit
// - Source bytes fetched sequentially from start
// - Eight-bit result returned on completion
// - Bit one destination, bit two source error
`timescale 1ns/1ps
`default_nettype none
module flash_program_param_check
    import flash_prog_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Initialization call
    input wire logic init_req_in,
    input wire logic [15:0] freq_setting_in,
    input wire logic [31:0] branch_addr_in,
    // Programming call
    input wire logic prog_req_in,
    input wire call_params_t params_in,
    // Result back to the caller
    output logic [7:0] result_reg_low_out,
    output logic done_out,
    output logic busy_out,
    // Source memory read port
    output logic src_rd_out,
    output logic [31:0] src_addr_out,
    input wire logic [7:0] src_data_in,
    // Flash write port
    output logic flash_wr_out,
    output flash_write_t flash_write_out
);
    // Address range helpers, used for several checks
    function automatic logic in_flash(input logic [31:0] a);
        in_flash = (a >= FLASH_BASE) && (a <= FLASH_LIMIT);
    endfunction : in_flash

    // Area of the downloaded routine; a branch or a source there is refused
    function automatic logic in_download(input logic [31:0] a);
        in_download = (a >= DL_BASE) && (a <= DL_LIMIT);
    endfunction : in_download

    // Sequencer registers
    seq_state_t state; // Sequencer state
    logic [31:0] dest_start_address; // Latched destination
    logic [31:0] source_start_address; // Latched source
    logic [PAGE_IDX_W:0] count; // Byte counter, one bit wider
    logic dest_addr_error; // Held check result
    logic source_addr_error; // Held check result
    logic [7:0] rd_data; // Buffer read data
    logic [PAGE_IDX_W-1:0] idx; // Low counter bits

    // Parameter checks, computed from latched values
    // The whole page must fit in flash, not just its first byte
    wire dest_outside = !in_flash(dest_start_address) ||
        !in_flash(dest_start_address + 32'h0000_007F);
    wire dest_unaligned = dest_start_address[6:0] != ALIGN_ZERO;
    wire src_bad = in_flash(source_start_address) ||
        in_download(source_start_address);
    wire any_error = dest_outside || dest_unaligned || src_bad;
    wire last_byte = count == 8'(PAGE_BYTES - 1);
    assign idx = count[PAGE_IDX_W-1:0];

    // Initialization checks
    // Sampled straight from the call inputs; the answer is ready one edge later
    wire branch_bad = (branch_addr_in != 32'h0000_0000) &&
        in_download(branch_addr_in);
    wire freq_bad = (freq_setting_in < FREQ_MIN) || (freq_setting_in > FREQ_MAX);

    // Initialization answer; reserved bits seven to three are constant zero
    wire [7:0] init_result = {5'h00, branch_bad, freq_bad,
        branch_bad | freq_bad};
    // Programming answer from the flags held since the check state; the
    // success/fail bit is simply the OR of the two address errors
    wire [7:0] prog_result = {5'h00, source_addr_error, dest_addr_error,
        source_addr_error | dest_addr_error};

    // Staging strobe: the byte answered by the source lands in the buffer
    wire buf_wr_en = state == WAIT_RD;
    // The buffer read port is registered, so the byte leaving it belongs
    // to the previous index; the flash address trails the counter by one
    wire [PAGE_IDX_W-1:0] write_offset = 7'(count - 8'h01);
    wire [31:0] write_addr = dest_start_address + {25'h0000000, write_offset};
    // First write cycle only primes the buffer read and writes nothing
    wire write_prime = count == 8'h00;
    // Counter has passed the last staged byte
    wire write_last = count == 8'(PAGE_BYTES);

    // Page buffer keeps fetched bytes until the whole page is in
    // Write and read share the counter index, one pass each
    page_buffer u_buf (
        .clk_in(clk_in),
        .wr_en_in(buf_wr_en),
        .wr_idx_in(idx),
        .wr_data_in(src_data_in),
        .rd_idx_in(idx),
        .rd_data_out(rd_data)
    );

    // Handshake outputs
    assign busy_out = state != IDLE;
    assign src_rd_out = state == FETCH;
    // Source address walks up from the latched start, one byte per fetch
    assign src_addr_out = source_start_address + {24'h000000, count};

    // Main sequencer: idle, check, then 128 fetch and stage pairs, then 129
    // write cycles, then the answer. Staging the whole page first keeps every
    // check ahead of the first flash strobe, at the cost of a 128-byte buffer
    // and a second pass over it.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // Idle, no strobes, result cleared
            state <= IDLE;
            dest_start_address <= 32'h0000_0000;
            source_start_address <= 32'h0000_0000;
            count <= '0;
            dest_addr_error <= 1'b0;
            source_addr_error <= 1'b0;
            result_reg_low_out <= RESULT_RESET;
            done_out <= 1'b0;
            flash_wr_out <= 1'b0;
            flash_write_out <= '0;
        end else begin
            // Strobes are one-cycle pulses unless a state raises them
            done_out <= 1'b0;
            flash_wr_out <= 1'b0;
            case (state)
                // Only this state looks at requests; calls while busy are lost
                // Waiting for a call; initialization wins when both arrive
                IDLE: begin
                    if (init_req_in) begin
                        // Upper bits are reserved and read zero
                        result_reg_low_out <= init_result;
                        done_out <= 1'b1;
                    end else if (prog_req_in) begin
                        // Parameters latched once; caller owns their format
                        dest_start_address <= params_in.reg_a;
                        source_start_address <= params_in.reg_b;
                        state <= CHECK;
                    end
                end

                // One cycle to register the check flags
                CHECK: begin
                    // All checks settle before any flash write
                    // Flags are kept for the answer; any error skips the fetch
                    dest_addr_error <= dest_outside | dest_unaligned;
                    source_addr_error <= src_bad;
                    count <= '0;
                    if (any_error) begin
                        state <= DONE;
                    end else begin
                        state <= FETCH;
                    end
                end

                // Strobe the source for the byte at the counter
                FETCH: begin
                    // Short pages arrive already padded with FF by the caller
                    state <= WAIT_RD;
                end

                // Source answers now; the buffer stages it at this edge
                WAIT_RD: begin
                    if (last_byte) begin
                        // Whole page staged, rewind for the write pass
                        count <= '0;
                        state <= WRITE;
                    end else begin
                        // Next byte of the source buffer
                        count <= count + 8'h01;
                        state <= FETCH;
                    end
                end

                // One byte to the flash per cycle, in ascending order
                WRITE: begin
                    // Read data lags one cycle, so write the previous index
                    if (!write_prime) begin
                        flash_wr_out <= 1'b1;
                        flash_write_out.addr <= write_addr;
                        flash_write_out.data <= rd_data;
                    end
                    // Index 128 flushes the last byte out of the buffer
                    if (write_last) begin
                        state <= DONE;
                    end else begin
                        count <= count + 8'h01;
                    end
                end

                // Answer the programming call and return to idle
                DONE: begin
                    result_reg_low_out <= prog_result;
                    done_out <= 1'b1;
                    state <= IDLE;
                end

                // Unused encodings fall back to idle
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule : flash_program_param_check
`default_nettype wire

// file: tb/flash_prog_monitor.sv
// Port checker for the flash page sequencer, bound to it below.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_monitor
    import flash_prog_pkg::*;
(
    // Watched ports
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic init_req_in,
    input wire logic prog_req_in,
    input wire logic [7:0] result_reg_low_out,
    input wire logic done_out,
    input wire logic busy_out,
    input wire logic src_rd_out,
    input wire logic [31:0] src_addr_out,
    input wire logic flash_wr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire take_w = !busy_out && (init_req_in || prog_req_in); // Call accepted
    wire [7:0] res_w = result_reg_low_out; // Short alias
    logic [7:0] wr_cnt; // Flash strobes since the call
    logic is_prog; // Last call was programming
    // Restarted per call, so a page is counted whole
    always_ff @(posedge clk_in) begin
        if (rst_in || take_w) begin
            wr_cnt <= 8'h00;
            is_prog <= !init_req_in;
        end else if (flash_wr_out) begin
            wr_cnt <= wr_cnt + 8'h01;
        end
    end
    chk_init_answer: assert property (init_req_in && take_w
        |=> done_out && res_w[7:3] == 5'h00) else $error("init answer wrong");
    chk_fail_flags: assert property (done_out
        |-> res_w[0] == (res_w[1] | res_w[2])) else $error("fail bit wrong");
    chk_page_len: assert property (done_out && is_prog && res_w == 8'h00
        |-> wr_cnt == 8'h80) else $error("page length wrong");
    chk_err_clean: assert property (done_out && res_w[2:1] != 2'b00
        |-> wr_cnt == 8'h00) else $error("flash written on error");
    chk_err_early: assert property (prog_req_in && take_w && !init_req_in
        ##3 done_out |-> res_w[2:1] != 2'b00) else $error("early done without error");
    chk_done_pulse: assert property (done_out
        |-> !busy_out ##1 !done_out) else $error("done not a pulse");
    chk_src_step: assert property (src_rd_out ##2 src_rd_out
        |-> src_addr_out == $past(src_addr_out, 2) + 32'h1) else $error("source skip");
    chk_idle_quiet: assert property (!busy_out
        |-> !flash_wr_out && !src_rd_out) else $error("strobe while idle");
    cover property (done_out && is_prog && res_w == 8'h00);
    cover property (done_out && is_prog && res_w[2:1] != 2'b00);
    cover property (done_out && !is_prog && res_w[0]);
    cover property (done_out && !is_prog && res_w == 8'h00);
endmodule : flash_prog_monitor
bind flash_program_param_check flash_prog_monitor mon (.clk_in(clk_in), .rst_in(rst_in),
    .init_req_in(init_req_in), .prog_req_in(prog_req_in),
    .result_reg_low_out(result_reg_low_out), .done_out(done_out), .busy_out(busy_out),
    .src_rd_out(src_rd_out), .src_addr_out(src_addr_out), .flash_wr_out(flash_wr_out));
`default_nettype wire

// file: tb/src_mem_model.sv
// Source memory seen by the sequencer: answers one cycle after the strobe.
// Assumes page-aligned source buffers; bytes from offset 0x70 are padding.
`timescale 1ns/1ps
`default_nettype none
module src_mem_model (
    // Read port
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic [31:0] addr_in,
    output logic [7:0] data_out
);
    // Held data goes stale after one cycle, so it is inverted
    always @(posedge clk_in) begin
        if (rd_in) begin
            data_out <= (addr_in[6:0] >= 7'h70) ? 8'hFF : addr_in[7:0] ^ 8'h5A;
        end else begin
            data_out <= ~data_out;
        end
    end
endmodule : src_mem_model
`default_nettype wire

// file: tb/test_flash_program_param_check.sv
// Self-checking bench: init and programming calls with expected results.
// Assumes the source memory model above and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_param_check;
    import flash_prog_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic init_req = 1'b0;
    logic prog_req = 1'b0;
    logic [15:0] freq = 16'h0000;
    logic [31:0] branch = 32'h0;
    call_params_t params = '0;
    logic [7:0] result, src_data;
    logic done, busy, src_rd, flash_wr;
    logic [31:0] src_addr, sa, dest;
    flash_write_t fw;
    int n_fail = 0;
    int compares = 0;
    int n_wr = 0;
    always #50 clk_in = ~clk_in;
    flash_program_param_check dut (.clk_in(clk_in), .rst_in(rst_in), .init_req_in(init_req),
        .freq_setting_in(freq), .branch_addr_in(branch), .prog_req_in(prog_req),
        .params_in(params), .result_reg_low_out(result), .done_out(done), .busy_out(busy),
        .src_rd_out(src_rd), .src_addr_out(src_addr), .src_data_in(src_data),
        .flash_wr_out(flash_wr), .flash_write_out(fw));
    src_mem_model mem (.clk_in(clk_in), .rd_in(src_rd), .addr_in(src_addr), .data_out(src_data));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    // One call, then the result byte and the flash write count
    task automatic call(input logic ini, input logic [31:0] a, input logic [31:0] b,
            input logic [7:0] exp, input int nw);
        int t;
        @(posedge clk_in);
        n_wr = 0;
        dest = a;
        sa = b;
        init_req <= ini;
        prog_req <= !ini;
        freq <= a[15:0];
        branch <= b;
        params <= '{a, b};
        @(posedge clk_in);
        init_req <= 1'b0;
        prog_req <= 1'b0;
        @(negedge clk_in);
        check({39'h0, busy}, {39'h0, !ini});
        t = 0;
        while (done !== 1'b1 && ++t < 500) @(negedge clk_in);
        check({39'h0, done}, 40'h1);
        check(t, ini ? 0 : ((nw > 0) ? 387 : 2));
        check({32'h0, result}, {32'h0, exp});
        check(n_wr, nw);
    endtask : call
    // Each flash byte paired with the source byte at the same offset
    always @(negedge clk_in) begin
        if (flash_wr === 1'b1) begin
            check(fw, {dest + n_wr, (n_wr >= 112) ? 8'hFF : 8'(sa + n_wr) ^ 8'h5A});
            n_wr++;
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        check({28'h0, result, busy, done, flash_wr, src_rd}, 40'h0);
        call(1'b1, 32'h09C4, 32'h0, 8'h00, 0);
        call(1'b1, 32'h031F, 32'h00FFB100, 8'h07, 0);
        call(1'b1, 32'h0320, 32'h00FF8000, 8'h00, 0);
        call(1'b1, 32'h031F, 32'h0, 8'h03, 0);
        call(1'b1, 32'h09C5, 32'h0, 8'h03, 0);
        call(1'b1, 32'h0320, 32'h00FFB100, 8'h05, 0);
        call(1'b0, 32'h00001081, 32'h00FF8000, 8'h03, 0);
        call(1'b0, 32'h00080000, 32'h00FF8000, 8'h03, 0);
        call(1'b0, 32'h00001000, 32'h00002000, 8'h05, 0);
        call(1'b0, 32'h00001000, 32'h00FFB000, 8'h05, 0);
        call(1'b0, 32'h00001081, 32'h00002000, 8'h07, 0);
        call(1'b0, 32'h0007FF80, 32'h00FF8000, 8'h00, 128);
        conclude();
    end
    // Watchdog well past the expected run length
    initial begin
        #500000;
        n_fail++;
        conclude();
    end
endmodule : test_flash_program_param_check
`default_nettype wire
